// ==== hw/adsq_defs.svh ====
/*
  Constants of the two-unit converter sequencer: register offsets, field
  positions, reset values and code points.
  Assumes a plain register port with a 5-bit word address and 16-bit data.
*/
// How it works
// RL1: writing start bit 0 aborts conversion and returns the unit to idle.
// RL2: writing start 1 begins; single mode clears start when done.
// RL3: continuous scan repeats the group until start is cleared.
// RL4: with auto-clear set, one scan pass clears start then stops.
// RL5: hardware clears start one cycle before it sets the end flag.
// RL6: software writes clock extension and clock select together.
// RL7: unit 0 single codes 0000-0111 pick inputs 0-7; top bit prohibited.
// RL8: unit 0 four-scan: bit 2 picks group start 0/4, low bits count.
// RL9: unit 0 eight-scan converts inputs 0 through n; top bit prohibited.
// RL10: full unit 1 needs channel bit 3 set, maps inputs 8 to 15.
// RL11: reduced unit 1 accepts only 1100/1101; eight-scan prohibited.
// RL12: end flag sets on single completion or full scan pass completion.
// RL13: end flag clears on 0 after reading 1, or transfer result read.
// RL14: writing 1 to the end flag has no effect.
// RL15: interrupt request follows end flag while interrupt enable is 1.
// RL16: unit 0 trigger codes pick timer, eight-bit timer, pin A, pin B.
// RL17: codes 011, 101, 111 start both units at once.
// RL18: unit 1 trigger 010/100/110 decode; code 001 prohibited.
// RL19: scan enable and size choose single, four-scan or eight-scan.
// RL20: clock codes x01/x10/x11 divide by 4/2/1; x00 prohibited.
// RL21: software picks clock while stopped; sets 11 before standby.
// RL22: result stored left-justified in bits 15:6, low six read zero.
// RL23: continuous scan restarts at the group's first channel each pass.
// RL24: per channel start/done handshake; result captured before advancing.
`ifndef ADSQ_DEFS_SVH
`define ADSQ_DEFS_SVH

`define ADSQ_OFF_CSR0      5'h00
`define ADSQ_OFF_CTRL0     5'h01
`define ADSQ_OFF_CSR1      5'h02
`define ADSQ_OFF_CTRL1     5'h03
`define ADSQ_OFF_RES0      5'h10
`define ADSQ_OFF_RES1      5'h18

`define ADSQ_BIT_END_FLAG  7
`define ADSQ_BIT_START     5

`define ADSQ_RST_CSR       8'h00
`define ADSQ_RST_CTRL      8'h00
`define ADSQ_RST_RES       10'h000
`define ADSQ_RES_PAD       6'h00

`define ADSQ_CLK_PROHIB    2'h0

`define ADSQ_TRG_NONE      3'h0
`define ADSQ_TRG_PULSE     3'h2
`define ADSQ_TRG_TIMER8    3'h4
`define ADSQ_TRG_OWN_PIN   3'h6
`define ADSQ_TRG_PIN_B     3'h1
`define ADSQ_TRG_SIM_PULSE 3'h3
`define ADSQ_TRG_SIM_TMR8  3'h5
`define ADSQ_TRG_SIM_PIN_B 3'h7

`endif

// ==== hw/adsq_pkg.sv ====
/*
  Types of the converter sequencer: register layouts, core handshake
  bundles and the unit state.
  Assumes adsq_defs.svh is on the include path.
*/
`default_nettype none
package adsq_pkg;

  typedef struct packed {
    logic       conv_end_flag;
    logic       end_irq_enable;
    logic       conv_start_bit;
    logic       clock_extend_sel;
    logic [3:0] chan_sel;
  } adsq_csr_t;

  typedef struct packed {
    logic       timer_trig_sel_hi;
    logic       timer_trig_sel_lo;
    logic       scan_enable_bit;
    logic       scan_size_sel;
    logic [1:0] clk_sel;
    logic       start_autoclear;
    logic       extended_trig_sel;
  } adsq_ctrl_t;

  typedef struct packed {
    logic       req;
    logic [3:0] chan;
    logic       clock_extend_sel;
    logic [1:0] clk_sel;
  } adsq_core_req_t;

  typedef struct packed {
    logic       done;
    logic [9:0] data;
  } adsq_core_rsp_t;

  typedef enum logic [1:0] {
    ADSQ_IDLE,
    ADSQ_CONV,
    ADSQ_GAP,
    ADSQ_FIN
  } adsq_state_t;

endpackage
`default_nettype wire

// ==== hw/adsq_top.sv ====
/*
  Two-unit successive-approximation converter sequencer: control and status
  registers, trigger decode, channel walk and result store per unit.
  Assumes an analog core per unit answering each request with a one-cycle
  done pulse, timer triggers as one-cycle pulses on clk_i, and trigger pins
  arriving asynchronously.
*/
// Local design decisions: the address map and the address-and-strobe port.
`include "adsq_defs.svh"
`default_nettype none
module adsq_top
  import adsq_pkg::*;
#(
  parameter bit UNIT1_FULL = 1'b1
) (
  // clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_n_i,
  // register port
  input  wire logic [4:0]           addr_i,
  input  wire logic [15:0]          wdata_i,
  input  wire logic                 wr_i,
  input  wire logic                 rd_i,
  output logic      [15:0]          rdata_o,
  // trigger sources and transfer status
  input  wire logic                 pulse_timer_trig_i,
  input  wire logic                 eight_bit_timer_trig_i,
  input  wire logic                 unit0_trigger_pin_a_i,
  input  wire logic                 unit0_trigger_pin_b_i,
  input  wire logic                 unit1_trigger_pin_i,
  input  wire logic [1:0]           xfer_active_i,
  // analog cores
  output adsq_core_req_t [1:0]      core_req_o,
  input  wire adsq_core_rsp_t [1:0] core_rsp_i,
  // interrupts
  output logic [1:0]                conv_end_irq_o
);

  // pin synchronisers: stages 0,1 synchronise, stage 2 is edge history
  logic [2:0] pin_sync_q [3];
  logic [2:0] pin_sync_d [3];
  logic [2:0] pin_raw;
  logic [2:0] pin_rise;
  logic [1:0] sim_hit;
  logic       sim_start;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;

  assign pin_raw = {unit1_trigger_pin_i, unit0_trigger_pin_b_i,
                    unit0_trigger_pin_a_i};

  for (genvar p = 0; p < 3; p++) begin : pin
    always_comb begin
      pin_sync_d[p] = {pin_sync_q[p][1:0], pin_raw[p]};
    end
    always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
        pin_sync_q[p] <= 3'h0;
      end else begin
        pin_sync_q[p] <= pin_sync_d[p];
      end
    end
    // only stage 1 and 2 are looked at; stage 0 may be metastable
    assign pin_rise[p] = pin_sync_q[p][1] & ~pin_sync_q[p][2];
  end

  for (genvar u = 0; u < 2; u++) begin : unit
    localparam logic [4:0] CSR_OFF  = (u == 0) ? `ADSQ_OFF_CSR0
                                               : `ADSQ_OFF_CSR1;
    localparam logic [4:0] CTRL_OFF = (u == 0) ? `ADSQ_OFF_CTRL0
                                               : `ADSQ_OFF_CTRL1;
    localparam logic [4:0] RES_OFF  = (u == 0) ? `ADSQ_OFF_RES0
                                               : `ADSQ_OFF_RES1;
    localparam logic       UNIT_BIT = (u == 0) ? 1'b0 : 1'b1;

    adsq_csr_t      csr_q, csr_d;
    adsq_ctrl_t     ctrl_q, ctrl_d;
    adsq_state_t    st_q, st_d;
    adsq_core_req_t req_q, req_d;
    logic [2:0]     idx_q, idx_d;
    logic           seen_q, seen_d;
    logic           irq_q, irq_d;
    logic [9:0]     res_q [8];
    logic [9:0]     res_d [8];
    logic [2:0]     first;
    logic [2:0]     last;
    logic [2:0]     trg;
    logic           single;
    logic           legal;
    logic           own_hit;
    logic           res_rd;

    assign trg = {ctrl_q.timer_trig_sel_hi, ctrl_q.timer_trig_sel_lo,
                  ctrl_q.extended_trig_sel};
    assign res_rd = rd_i && (addr_i[4:3] == RES_OFF[4:3]);

    // channel group and legality of the current setting
    always_comb begin
      single = ~ctrl_q.scan_enable_bit;                         // RL19
      if (single) begin
        first = csr_q.chan_sel[2:0];                            // RL7
        last  = csr_q.chan_sel[2:0];
      end else if (!ctrl_q.scan_size_sel) begin
        first = {csr_q.chan_sel[2], 2'b00};                     // RL8
        last  = {csr_q.chan_sel[2], csr_q.chan_sel[1:0]};
      end else begin
        first = 3'h0;                                           // RL9
        last  = csr_q.chan_sel[2:0];
      end
      legal = (ctrl_q.clk_sel != `ADSQ_CLK_PROHIB);             // RL20
      if (u == 0) begin
        legal = legal && !csr_q.chan_sel[3];                    // RL7
      end else if (UNIT1_FULL) begin
        legal = legal && csr_q.chan_sel[3];                     // RL10
      end else begin
        legal = legal && (csr_q.chan_sel[3:1] == 3'b110)        // RL11
                && !(ctrl_q.scan_enable_bit && ctrl_q.scan_size_sel);
      end
    end

    // own trigger decode; simultaneous codes handled at top level
    always_comb begin
      unique case (trg)
        `ADSQ_TRG_PULSE:   own_hit = pulse_timer_trig_i;        // RL16
        `ADSQ_TRG_TIMER8:  own_hit = eight_bit_timer_trig_i;
        `ADSQ_TRG_OWN_PIN: own_hit = (u == 0) ? pin_rise[0]
                                              : pin_rise[2];    // RL18
        `ADSQ_TRG_PIN_B:   own_hit = (u == 0) ? pin_rise[1]
                                              : 1'b0;           // RL18
        default:           own_hit = 1'b0;
      endcase
    end

    always_comb begin
      csr_d  = csr_q;
      ctrl_d = ctrl_q;
      st_d   = st_q;
      req_d  = req_q;
      idx_d  = idx_q;
      seen_d = seen_q;
      res_d  = res_q;
      // register port
      if (rd_i && addr_i == CSR_OFF && csr_q.conv_end_flag) begin
        seen_d = 1'b1;
      end
      if (wr_i && addr_i == CSR_OFF) begin
        csr_d.end_irq_enable   = wdata_i[6];
        csr_d.conv_start_bit   = wdata_i[`ADSQ_BIT_START];      // RL1 RL2
        csr_d.clock_extend_sel = wdata_i[4];                    // RL6
        csr_d.chan_sel         = wdata_i[3:0];
        // a 1 never sets the flag; a 0 clears only after a read of 1
        if (!wdata_i[`ADSQ_BIT_END_FLAG] && seen_q) begin       // RL14
          csr_d.conv_end_flag = 1'b0;                           // RL13
        end
        seen_d = 1'b0;
      end
      if (wr_i && addr_i == CTRL_OFF) begin
        ctrl_d = adsq_ctrl_t'(wdata_i[7:0]);                    // RL6 RL21
      end
      if (res_rd && xfer_active_i[u]) begin
        csr_d.conv_end_flag = 1'b0;                             // RL13
      end
      if (own_hit || sim_start) begin
        csr_d.conv_start_bit = 1'b1;                            // RL16 RL17
      end
      // sequencer; flag sets below win over the clears above
      unique case (st_q)
        ADSQ_IDLE: begin
          if (csr_q.conv_start_bit) begin
            if (legal) begin
              idx_d     = first;
              req_d.req = 1'b1;                                 // RL2 RL24
              st_d      = ADSQ_CONV;
            end else begin
              csr_d.conv_start_bit = 1'b0;
            end
          end
        end
        ADSQ_CONV: begin
          if (!csr_q.conv_start_bit) begin
            req_d.req = 1'b0;                                   // RL1
            st_d      = ADSQ_IDLE;
          end else if (core_rsp_i[u].done) begin
            res_d[idx_q] = core_rsp_i[u].data;                  // RL24
            req_d.req    = 1'b0;
            st_d         = ADSQ_GAP;
            if (idx_q == last) begin
              if (single || ctrl_q.start_autoclear) begin
                csr_d.conv_start_bit = 1'b0;                    // RL2 RL4
                st_d                 = ADSQ_FIN;                // RL5
              end else begin
                csr_d.conv_end_flag = 1'b1;                     // RL12
                idx_d               = first;                    // RL3 RL23
              end
            end else begin
              idx_d = idx_q + 3'h1;
            end
          end
        end
        ADSQ_GAP: begin
          // one idle cycle between channels keeps req edges distinct
          if (!csr_q.conv_start_bit) begin
            st_d = ADSQ_IDLE;                                   // RL1
          end else begin
            req_d.req = 1'b1;                                   // RL24
            st_d      = ADSQ_CONV;
          end
        end
        ADSQ_FIN: begin
          csr_d.conv_end_flag = 1'b1;                           // RL5 RL12
          st_d                = ADSQ_IDLE;
        end
      endcase
      req_d.chan             = {UNIT_BIT, idx_d};               // RL10
      req_d.clock_extend_sel = csr_q.clock_extend_sel;          // RL20
      req_d.clk_sel          = ctrl_q.clk_sel;
      irq_d = csr_d.conv_end_flag & csr_d.end_irq_enable;       // RL15
    end

    always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
        csr_q  <= adsq_csr_t'(`ADSQ_RST_CSR);
        ctrl_q <= adsq_ctrl_t'(`ADSQ_RST_CTRL);
        st_q   <= ADSQ_IDLE;
        req_q  <= '0;
        idx_q  <= 3'h0;
        seen_q <= 1'b0;
        irq_q  <= 1'b0;
        for (int i = 0; i < 8; i++) begin
          res_q[i] <= `ADSQ_RST_RES;
        end
      end else begin
        csr_q  <= csr_d;
        ctrl_q <= ctrl_d;
        st_q   <= st_d;
        req_q  <= req_d;
        idx_q  <= idx_d;
        seen_q <= seen_d;
        irq_q  <= irq_d;
        res_q  <= res_d;
      end
    end

    assign core_req_o[u]     = req_q;
    assign conv_end_irq_o[u] = irq_q;
  end

  // simultaneous start codes from either unit start both units
  always_comb begin
    for (int v = 0; v < 2; v++) begin
      sim_hit[v] = 1'b0;
    end
    unique case ({unit[0].trg})
      `ADSQ_TRG_SIM_PULSE: sim_hit[0] = pulse_timer_trig_i;     // RL17
      `ADSQ_TRG_SIM_TMR8:  sim_hit[0] = eight_bit_timer_trig_i;
      `ADSQ_TRG_SIM_PIN_B: sim_hit[0] = pin_rise[1];
      default:             sim_hit[0] = 1'b0;
    endcase
    unique case ({unit[1].trg})
      `ADSQ_TRG_SIM_PULSE: sim_hit[1] = pulse_timer_trig_i;     // RL17
      `ADSQ_TRG_SIM_TMR8:  sim_hit[1] = eight_bit_timer_trig_i;
      `ADSQ_TRG_SIM_PIN_B: sim_hit[1] = pin_rise[1];
      default:             sim_hit[1] = 1'b0;
    endcase
  end
  assign sim_start = |sim_hit;

  // read data, valid the cycle after the strobe; unmapped reads zero
  always_comb begin
    rdata_d = 16'h0000;
    if (rd_i) begin
      if (addr_i == `ADSQ_OFF_CSR0) begin
        rdata_d = {8'h00, unit[0].csr_q};
      end else if (addr_i == `ADSQ_OFF_CTRL0) begin
        rdata_d = {8'h00, unit[0].ctrl_q};
      end else if (addr_i == `ADSQ_OFF_CSR1) begin
        rdata_d = {8'h00, unit[1].csr_q};
      end else if (addr_i == `ADSQ_OFF_CTRL1) begin
        rdata_d = {8'h00, unit[1].ctrl_q};
      end else if (unit[0].res_rd) begin
        rdata_d = {unit[0].res_q[addr_i[2:0]], `ADSQ_RES_PAD};  // RL22
      end else if (unit[1].res_rd) begin
        rdata_d = {unit[1].res_q[addr_i[2:0]], `ADSQ_RES_PAD};  // RL22
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata_o = rdata_q;

endmodule
`default_nettype wire

// ==== testbench/adsq_chk.sv ====
/*
  Port checker of adsq_top, attached by the bind at the foot.
  Assumes one clock domain and the synchronous active-low reset.
*/
`include "adsq_defs.svh"
`default_nettype none
module adsq_chk
  import adsq_pkg::*;
(
  // watched top ports
  input wire logic                 clk_i,
  input wire logic                 rst_n_i,
  input wire logic [4:0]           addr_i,
  input wire logic [15:0]          wdata_i,
  input wire logic                 wr_i,
  input wire logic                 rd_i,
  input wire logic [15:0]          rdata_o,
  input wire logic [1:0]           xfer_active_i,
  input wire adsq_core_req_t [1:0] core_req_o,
  input wire adsq_core_rsp_t [1:0] core_rsp_i,
  input wire logic [1:0]           conv_end_irq_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  logic [1:0] req_w;
  logic [1:0] done_w;
  logic       wr0_w;
  assign req_w  = {core_req_o[1].req, core_req_o[0].req};
  assign done_w = {core_rsp_i[1].done, core_rsp_i[0].done};
  assign wr0_w  = wr_i && addr_i == `ADSQ_OFF_CSR0;

  chk_req_drop: assert property (
    req_w[0] && done_w[0] |=> !req_w[0])
    else $error("request held after done");
  // a csr write may abort, so its two cycles are left out
  chk_req_hold: assert property (
    req_w[0] && !done_w[0] && !wr0_w && !$past(wr0_w)
    |=> req_w[0] && $stable(core_req_o[0].chan))
    else $error("request dropped or moved early");
  chk_sw_abort: assert property (
    wr0_w && !wdata_i[5] |-> ##[1:3] !req_w[0])
    else $error("conversion not aborted");
  chk_u0_chan: assert property (
    req_w[0] |-> !core_req_o[0].chan[3])
    else $error("unit 0 converts a prohibited input");
  chk_u1_chan: assert property (
    req_w[1] |-> core_req_o[1].chan[3])
    else $error("unit 1 converts a prohibited input");
  chk_clk_legal: assert property (
    req_w[0] |-> core_req_o[0].clk_sel != 2'h0)
    else $error("conversion with prohibited clock code");
  chk_irq_rise: assert property (
    $rose(conv_end_irq_o[0])
    |-> $past(done_w[0]) || $past(done_w[0], 2) || $past(wr_i))
    else $error("interrupt raised without cause");
  chk_irq_fall: assert property (
    $fell(conv_end_irq_o[0]) |-> $past(wr_i) || $past(xfer_active_i[0])
    || $past(xfer_active_i[0], 2))
    else $error("interrupt dropped without cause");
  chk_res_pad: assert property (
    $past(rd_i) && $past(addr_i[4]) |-> rdata_o[5:0] == 6'h00)
    else $error("result low bits not zero");

  cover property (req_w == 2'h3);
  cover property (done_w[1]);
  cover property ($rose(conv_end_irq_o[0]));
endmodule

bind adsq_top adsq_chk u_adsq_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .xfer_active_i(xfer_active_i),
  .core_req_o(core_req_o), .core_rsp_i(core_rsp_i),
  .conv_end_irq_o(conv_end_irq_o));
`default_nettype wire

// ==== testbench/adsq_core_model.sv ====
/*
  Behavioural model of the two analog converter cores.
  Assumes the request bundles of adsq_top; answer delay set by lat_i.
*/
`default_nettype none
module adsq_core_model
  import adsq_pkg::*;
(
  // clock, reset and pacing
  input  wire logic                 clk_i,
  input  wire logic                 rst_n_i,
  input  wire logic [3:0]           lat_i,
  // core link
  input  wire adsq_core_req_t [1:0] core_req_i,
  output adsq_core_rsp_t [1:0]      core_rsp_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q [2];
  logic [9:0] last_q [2];
  logic [1:0] done_q;
  always_ff @(posedge clk_i) begin
    for (int u = 0; u < 2; u++) begin
      if (!rst_n_i || !core_req_i[u].req || done_q[u]) begin
        cnt_q[u]  <= 4'h0;
        done_q[u] <= 1'b0;
      end else begin
        cnt_q[u]  <= cnt_q[u] + 4'h1;
        done_q[u] <= cnt_q[u] == lat_i;
      end
      if (!rst_n_i) begin
        last_q[u] <= 10'h000;
      end else if (done_q[u]) begin
        last_q[u] <= core_rsp_o[u].data;
      end
    end
  end
  // idle data lines show the inverse of the last answer, never a hold
  always_comb begin
    for (int u = 0; u < 2; u++) begin
      core_rsp_o[u].done = done_q[u];
      core_rsp_o[u].data = done_q[u] ? {core_req_i[u].chan, 6'h15}
                                     : ~last_q[u];
    end
  end
endmodule
`default_nettype wire

// ==== testbench/adsq_top_tb.sv ====
/*
  Self-checking bench of adsq_top driving the core model.
  Assumes a full unit 1 and the register map of adsq_defs.svh.
*/
`include "adsq_defs.svh"
`default_nettype none
module adsq_top_tb import adsq_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 clk_i, rst_n_i, wr_i, rd_i;
  logic [4:0]           addr_i, src;
  logic [15:0]          wdata_i, rdata_o, rv;
  logic [3:0]           lat, ch;
  logic [1:0]           xfer, irq;
  adsq_core_req_t [1:0] req;
  adsq_core_rsp_t [1:0] rsp;
  int                   n_errors, num_checks, cyc, u;
  logic [31:0]          seed = 32'h0000_41BE;
  logic [4:0]           ra [6] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h08, 5'h10};
  // {unit, trigger code, source, both units}
  logic [7:0]           tt [10] = '{8'h20, 8'h42, 8'h64, 8'h16, 8'h31,
                                    8'h53, 8'h77, 8'hA0, 8'hC2, 8'hE8};

  adsq_top #(.UNIT1_FULL(1'b1)) u_adsq_top (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .pulse_timer_trig_i(src[0]),
    .eight_bit_timer_trig_i(src[1]), .unit0_trigger_pin_a_i(src[2]),
    .unit0_trigger_pin_b_i(src[3]), .unit1_trigger_pin_i(src[4]),
    .xfer_active_i(xfer), .core_req_o(req), .core_rsp_i(rsp),
    .conv_end_irq_o(irq));
  adsq_core_model u_adsq_core_model (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .lat_i(lat), .core_req_i(req), .core_rsp_o(rsp));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [15:0] exp_res(input logic [3:0] c);
    return {c, 6'h15, 6'h00};
  endfunction
  function automatic logic [7:0] ctrl(input logic [2:0] t,
                                      input logic [1:0] m, input logic a);
    return {t[2:1], m, 2'h3, a, t[0]};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= {8'h00, d};
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 rv = rdata_o;
  endtask
  task automatic wait_irq(input int n);
    int k = 0;
    while (irq[n] !== 1'b1 && k < 3000) begin
      @(posedge clk_i);
      k++;
    end
    chk({15'h0000, irq[n]}, 16'h0001);
  endtask
  // read first so that the write of 0 may clear the flag
  task automatic clr(input int n);
    rd(`ADSQ_OFF_CSR0 + 5'(2 * n));
    wr(`ADSQ_OFF_CSR0 + 5'(2 * n), rv[7:0] & 8'h5F);
  endtask
  // pins pass a synchroniser, so they stay up for several cycles
  task automatic fire(input int i);
    @(posedge clk_i);
    src[i] <= 1'b1;
    repeat (i < 2 ? 1 : 4) @(posedge clk_i);
    src[i] <= 1'b0;
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      $display("mismatch %0t run too long", $time);
      summarize();
    end
  end

  initial begin
    {rst_n_i, wr_i, rd_i, addr_i, wdata_i, src, xfer} = '0;
    lat = 4'h3;
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    foreach (ra[i]) begin
      rd(ra[i]);
      chk(rv, 16'h0000);
    end
    for (int m = 0; m < 2; m++) begin
      wr(`ADSQ_OFF_CTRL0, ctrl(3'h0, m ? 2'h2 : 2'h3, 1'b1));
      wr(`ADSQ_OFF_CSR0, m ? 8'h66 : 8'h65);
      wait_irq(0);
      rd(`ADSQ_OFF_CSR0);
      chk(rv, m ? 16'h00C6 : 16'h00C5);
      for (int k = 4 * m; k < 8; k++) begin
        rd(`ADSQ_OFF_RES0 + 5'(k));
        chk(rv, k < 6 + m ? exp_res(4'(k)) : 16'h0000);
      end
      clr(0);
    end
    lat <= 4'hF;
    wr(`ADSQ_OFF_CTRL1, ctrl(3'h0, 2'h2, 1'b0));
    wr(`ADSQ_OFF_CSR1, 8'h6D);
    wait_irq(1);
    rd(`ADSQ_OFF_CSR1);
    chk(rv, 16'h00ED);
    wr(`ADSQ_OFF_CSR1, 8'h6D);
    wait_irq(1);
    wr(`ADSQ_OFF_CSR1, 8'h4D);
    repeat (3) @(posedge clk_i);
    chk({15'h0000, req[1].req}, 16'h0000);
    for (int k = 12; k < 14; k++) begin
      rd(`ADSQ_OFF_RES1 + 5'(k - 8));
      chk(rv, exp_res(4'(k)));
    end
    for (int n = 0; n < 2; n++) begin
      wr(`ADSQ_OFF_CSR0 + 5'(2 * n), n ? 8'h20 : 8'h28);
      repeat (3) @(posedge clk_i);
      clr(n);
      chk({15'h0000, rv[5]}, 16'h0000);
    end
    wr(`ADSQ_OFF_CTRL0, ctrl(3'h0, 2'h0, 1'b0));
    for (int i = 0; i < 8; i++) begin
      ch  = i == 0 ? 4'h7 : 4'(xs() % 8);
      lat <= 4'(xs());
      wr(`ADSQ_OFF_CSR0, 8'h60 | 8'(ch));
      wait_irq(0);
      rd(`ADSQ_OFF_CSR0);
      chk(rv, 16'(8'hC0 | 8'(ch)));
      rd(`ADSQ_OFF_RES0 + 5'(ch));
      chk(rv, exp_res(ch));
      if (i[0]) begin
        wr(`ADSQ_OFF_CSR0, 8'hC0 | 8'(ch));
        rd(`ADSQ_OFF_CSR0);
        chk({15'h0000, rv[7]}, 16'h0001);
        wr(`ADSQ_OFF_CSR0, 8'h40 | 8'(ch));
      end else begin
        @(posedge clk_i) xfer <= 2'h1;
        rd(`ADSQ_OFF_RES0);
        @(posedge clk_i) xfer <= 2'h0;
      end
      repeat (2) @(posedge clk_i);
      chk({15'h0000, irq[0]}, 16'h0000);
    end
    wr(`ADSQ_OFF_CSR1, 8'h48);
    foreach (tt[i]) begin
      u = int'(tt[i][7]);
      wr(`ADSQ_OFF_CTRL0 + 5'(2 * u), ctrl(tt[i][6:4], 2'h0, 1'b0));
      wr(`ADSQ_OFF_CTRL1 - 5'(2 * u), ctrl(3'h0, 2'h0, 1'b0));
      fire(int'(tt[i][3:1]));
      wait_irq(u);
      if (tt[i][0]) wait_irq(1);
      clr(0);
      clr(1);
    end
    wr(`ADSQ_OFF_CTRL1, ctrl(3'h0, 2'h0, 1'b0));
    fire(0);
    fire(4);
    repeat (20) @(posedge clk_i);
    chk({14'h0000, irq}, 16'h0000);
    summarize();
  end
endmodule
`default_nettype wire
